//--- rtl/dbg_pkg.sv
// How it works
// - debug logic off at reset; firmware enables
// - re-enable only after erase, unprotect, reprogram
// - lockout disables every external access port
// - pins used follow selected port configuration
// - scan port uses four pins, five with reset
// - scan pins default on; setting can release
// - default four-wire scan, data select input-only
// - two-wire selection makes select line bidirectional
// - switch back to scan makes line input-only
// - reset request accepted unless ports disabled
// - scan chains and device chaining on scan port
// - both ports reach debug commands; reset request on scan port only
// - switch from scan to two-wire needs acquire within window
package dbg_pkg;
    localparam int unsigned SYS_CLK_HZ = 10_000_000;
    localparam int unsigned ACQ_WINDOW_NS = 8000;
    localparam int unsigned ACQ_WINDOW_CYC =
        ACQ_WINDOW_NS * (SYS_CLK_HZ / 1_000_000) / 1000;
    localparam int unsigned TCK_MAX_HZ = 14_000_000;
    localparam logic [6:0] WIN_CNT_MAX = 7'(ACQ_WINDOW_CYC);
    localparam int unsigned ACQ_LEN = 16;
    localparam logic [15:0] ACQ_SEQ = 16'hb3c5;
    localparam int unsigned BS_LEN = 8;
    localparam int unsigned CMD_W = 8;
    localparam logic [7:0] CMD_TO_SCAN = 8'h3c;
    localparam logic [2:0] PINS_NONE = 3'h0;
    localparam logic [2:0] PINS_TRACE = 3'h1;
    localparam logic [2:0] PINS_SWD = 3'h2;
    localparam logic [2:0] PINS_SWD_TRACE = 3'h3;
    localparam logic [2:0] PINS_SCAN4 = 3'h4;
    localparam logic [2:0] PINS_SCAN5 = 3'h5;
    localparam logic [3:0] INSTR_EXTEST = 4'h0;
    localparam logic [3:0] INSTR_SAMPLE = 4'h1;
    localparam logic [3:0] INSTR_DEBUG = 4'h8;
    localparam logic [3:0] INSTR_RESET = 4'h9;
    localparam logic [3:0] INSTR_BYPASS = 4'hf;

    typedef enum logic [1:0] {
        PORT_NONE = 2'h0,
        PORT_SCAN4 = 2'h1,
        PORT_SCAN5 = 2'h3,
        PORT_SWD = 2'h2
    } port_sel_t;
    localparam port_sel_t NV_PORT_DEFAULT = PORT_SCAN4;

    typedef enum logic [2:0] {
        DBG_OFF = 3'h0,
        DBG_ON = 3'h1,
        DBG_SEALED = 3'h3,
        DBG_ERASED = 3'h2,
        DBG_CLEARED = 3'h6
    } dbg_state_t;

    typedef enum logic [3:0] {
        TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3,
        TAP_CAP_DR = 4'h2, TAP_SH_DR = 4'h6, TAP_EX1_DR = 4'h7,
        TAP_PAU_DR = 4'h5, TAP_EX2_DR = 4'h4, TAP_UPD_DR = 4'hc,
        TAP_SEL_IR = 4'hd, TAP_CAP_IR = 4'hf, TAP_SH_IR = 4'he,
        TAP_EX1_IR = 4'ha, TAP_PAU_IR = 4'hb, TAP_EX2_IR = 4'h9,
        TAP_UPD_IR = 4'h8
    } tap_state_t;

    typedef enum logic [2:0] {
        SW_IDLE = 3'h0,
        SW_RNW = 3'h1,
        SW_WDATA = 3'h3,
        SW_TURN = 3'h2,
        SW_RDATA = 3'h6
    } swd_state_t;
endpackage

//--- rtl/link_if.sv
`timescale 1ns/1ps
interface link_if;
    logic swd_on;
    logic acq_en;
    logic acq_tog;
    logic [7:0] cmd;
    logic cmd_tog;
    logic [7:0] rd_data;
    logic tms_o;
    logic tms_oe;
    modport eng(input swd_on, acq_en, rd_data,
        output acq_tog, cmd, cmd_tog, tms_o, tms_oe);
    modport top(output swd_on, acq_en, rd_data,
        input acq_tog, cmd, cmd_tog, tms_o, tms_oe);
endinterface

//--- rtl/sync_bits.sv
`timescale 1ns/1ps
module sync_bits #(
    parameter int unsigned W = 1
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;
    sync_t r;
    sync_t next_r;

    always_comb
    begin
        next_r.s1 = d_i;
        next_r.s2 = r.s1;
    end

    genvar i;
    for (i = 0; i < W; i++)
    begin : g_bit
        always_ff @(posedge clk_i or posedge reset_i)
        begin
            if (reset_i)
            begin
                r.s1[i] <= 1'b0;
                r.s2[i] <= 1'b0;
            end
            else
            begin
                r.s1[i] <= next_r.s1[i];
                r.s2[i] <= next_r.s2[i];
            end
        end
    end

    assign q_o = r.s2;
endmodule // sync_bits

//--- rtl/swd_engine.sv
`timescale 1ns/1ps
module swd_engine (
    input wire logic tck_i,
    input wire logic reset_i,
    input wire logic tms_i,
    link_if.eng lk
);
    typedef struct packed {
        logic [dbg_pkg::ACQ_LEN-1:0] acq_sh;
        logic acq_tog;
        dbg_pkg::swd_state_t st;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic [7:0] cmd;
        logic cmd_tog;
        logic tms_o;
        logic tms_oe;
    } eng_t;
    eng_t r;
    eng_t next_r;

    always_comb
    begin
        next_r = r;
        next_r.acq_sh = {r.acq_sh[dbg_pkg::ACQ_LEN-2:0], tms_i};
        if (lk.acq_en && next_r.acq_sh == dbg_pkg::ACQ_SEQ)
        begin
            next_r.acq_tog = ~r.acq_tog;
            next_r.st = dbg_pkg::SW_IDLE;
            next_r.tms_oe = 1'b0;
        end
        else if (!lk.swd_on)
        begin
            next_r.st = dbg_pkg::SW_IDLE;
            next_r.tms_oe = 1'b0;
        end
        else
        begin
            unique case (r.st)
                dbg_pkg::SW_IDLE:
                    if (tms_i)
                        next_r.st = dbg_pkg::SW_RNW;
                dbg_pkg::SW_RNW:
                begin
                    next_r.cnt = 3'h0;
                    next_r.st = tms_i ? dbg_pkg::SW_TURN
                                      : dbg_pkg::SW_WDATA;
                end
                dbg_pkg::SW_WDATA:
                begin
                    next_r.sh = {tms_i, r.sh[7:1]};
                    next_r.cnt = r.cnt + 3'h1;
                    if (r.cnt == 3'h7)
                    begin
                        next_r.cmd = {tms_i, r.sh[7:1]};
                        next_r.cmd_tog = ~r.cmd_tog;
                        next_r.st = dbg_pkg::SW_IDLE;
                    end
                end
                dbg_pkg::SW_TURN:
                begin
                    next_r.sh = lk.rd_data;
                    next_r.tms_o = lk.rd_data[0];
                    next_r.tms_oe = 1'b1;
                    next_r.st = dbg_pkg::SW_RDATA;
                end
                dbg_pkg::SW_RDATA:
                begin
                    next_r.sh = {1'b0, r.sh[7:1]};
                    next_r.tms_o = r.sh[1];
                    next_r.cnt = r.cnt + 3'h1;
                    if (r.cnt == 3'h7)
                    begin
                        next_r.tms_oe = 1'b0;
                        next_r.st = dbg_pkg::SW_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge tck_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign lk.acq_tog = r.acq_tog;
    assign lk.cmd = r.cmd;
    assign lk.cmd_tog = r.cmd_tog;
    assign lk.tms_o = r.tms_o;
    assign lk.tms_oe = r.tms_oe;
endmodule // swd_engine

//--- rtl/debug_port_access_control.sv
`timescale 1ns/1ps
module debug_port_access_control (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic test_reset_n_i,
    input wire logic [1:0] nv_port_select_i,
    input wire logic nv_trace_en_i,
    input wire logic nv_sealed_i,
    input wire logic lockout_i,
    input wire logic fw_debug_enable_i,
    input wire logic fw_seal_i,
    input wire logic erase_done_i,
    input wire logic protect_clear_i,
    input wire logic trace_data_i,
    input wire logic [7:0] pin_state_i,
    output logic tms_o,
    output logic tms_oe_o,
    output logic tdo_o,
    output logic tdo_oe_o,
    output logic [7:0] scan_out_o,
    output logic extest_o,
    output logic trace_o,
    output logic trace_oe_o,
    output logic debug_enable_o,
    output logic [7:0] dbg_cmd_o,
    output logic dbg_cmd_valid_o,
    output logic reset_req_o,
    output logic [2:0] pins_used_o,
    output logic [1:0] port_mode_o
);
    typedef struct packed {
        logic sampled;
        logic locked;
        dbg_pkg::port_sel_t mode;
        dbg_pkg::dbg_state_t dbg;
        logic [6:0] win_cnt;
        logic swd_acq;
        logic [3:0] tog_prev;
        logic [4:0] lvl;
        logic [7:0] dbg_cmd;
        logic dbg_cmd_valid;
        logic reset_req;
        logic trace;
        logic trace_oe;
        logic [2:0] pins_used;
    } sys_t;

    typedef struct packed {
        dbg_pkg::tap_state_t tap;
        logic [3:0] ir;
        logic [3:0] ir_sh;
        logic [7:0] dr_sh;
        logic [7:0] bs_out;
        logic extest;
        logic [7:0] cmd;
        logic cmd_tog;
        logic rst_tog;
        logic tdo;
        logic tdo_oe;
    } tck_t;

    sys_t s;
    sys_t next_s;
    tck_t t;
    tck_t next_t;
    link_if lk();

    logic [3:0] tog_s;
    logic [4:0] lvl_t;
    logic [8:0] pins_t;
    logic dbg_en_t;
    logic scan_on_t;
    logic scan5_t;
    logic one_bit_dr;
    logic tap_hold;

    sync_bits #(.W(4)) u_to_sys (
        .clk_i(sys_clk_i),
        .reset_i(reset_i),
        .d_i({lk.acq_tog, lk.cmd_tog, t.cmd_tog, t.rst_tog}),
        .q_o(tog_s)
    );

    sync_bits #(.W(14)) u_to_tck (
        .clk_i(tck_i),
        .reset_i(reset_i),
        .d_i({s.lvl, test_reset_n_i, pin_state_i}),
        .q_o({lvl_t, pins_t})
    );

    swd_engine u_swd (
        .tck_i(tck_i),
        .reset_i(reset_i),
        .tms_i(tms_i),
        .lk(lk)
    );

    // synchronised levels towards the link
    assign scan_on_t = lvl_t[4];
    assign scan5_t = lvl_t[3];
    assign lk.swd_on = lvl_t[2];
    assign lk.acq_en = lvl_t[1];
    assign dbg_en_t = lvl_t[0];
    assign lk.rd_data = {dbg_en_t, scan_on_t, scan5_t, lk.swd_on,
                         t.cmd[3:0]};

    // system side: straps, access state, window, event intake
    always_comb
    begin
        next_s = s;
        next_s.dbg_cmd_valid = 1'b0;
        next_s.reset_req = 1'b0;
        next_s.tog_prev = tog_s;
        if (!s.sampled)
        begin
            next_s.sampled = 1'b1;
            next_s.locked = lockout_i;
            next_s.mode = dbg_pkg::port_sel_t'(nv_port_select_i);
            next_s.swd_acq =
                (nv_port_select_i == dbg_pkg::PORT_SWD) && !lockout_i;
            next_s.dbg = nv_sealed_i ? dbg_pkg::DBG_SEALED
                                     : dbg_pkg::DBG_OFF;
        end
        else
        begin
            if (s.win_cnt != dbg_pkg::WIN_CNT_MAX)
                next_s.win_cnt = s.win_cnt + 7'h1;
            if ((tog_s[3] != s.tog_prev[3]) && !s.locked &&
                (s.win_cnt != dbg_pkg::WIN_CNT_MAX))
                next_s.swd_acq = 1'b1;
            if (tog_s[2] != s.tog_prev[2])
            begin
                if (lk.cmd == dbg_pkg::CMD_TO_SCAN && s.swd_acq)
                begin
                    next_s.swd_acq = 1'b0;
                    next_s.mode = dbg_pkg::PORT_SCAN4;
                end
                else if (s.dbg == dbg_pkg::DBG_ON)
                begin
                    next_s.dbg_cmd = lk.cmd;
                    next_s.dbg_cmd_valid = 1'b1;
                end
            end
            if ((tog_s[1] != s.tog_prev[1]) &&
                s.dbg == dbg_pkg::DBG_ON)
            begin
                next_s.dbg_cmd = t.cmd;
                next_s.dbg_cmd_valid = 1'b1;
            end
            if ((tog_s[0] != s.tog_prev[0]) && !s.locked &&
                s.mode != dbg_pkg::PORT_NONE)
                next_s.reset_req = 1'b1;
            unique case (s.dbg)
                dbg_pkg::DBG_OFF:
                    if (fw_debug_enable_i && !s.locked)
                        next_s.dbg = dbg_pkg::DBG_ON;
                    else if (fw_seal_i)
                        next_s.dbg = dbg_pkg::DBG_SEALED;
                dbg_pkg::DBG_ON:
                    next_s.dbg = dbg_pkg::DBG_ON;
                dbg_pkg::DBG_SEALED:
                    if (erase_done_i)
                        next_s.dbg = dbg_pkg::DBG_ERASED;
                dbg_pkg::DBG_ERASED:
                    if (protect_clear_i)
                        next_s.dbg = dbg_pkg::DBG_CLEARED;
                dbg_pkg::DBG_CLEARED:
                    if (fw_debug_enable_i && !s.locked)
                        next_s.dbg = dbg_pkg::DBG_ON;
                default:
                    next_s.dbg = dbg_pkg::DBG_OFF;
            endcase
        end
        next_s.lvl[4] = next_s.sampled && !next_s.locked &&
            !next_s.swd_acq && (next_s.mode == dbg_pkg::PORT_SCAN4 ||
            next_s.mode == dbg_pkg::PORT_SCAN5);
        next_s.lvl[3] = next_s.mode == dbg_pkg::PORT_SCAN5;
        next_s.lvl[2] = !next_s.locked && next_s.swd_acq;
        next_s.lvl[1] = next_s.sampled && !next_s.locked;
        next_s.lvl[0] = next_s.dbg == dbg_pkg::DBG_ON;
        next_s.trace_oe = nv_trace_en_i && next_s.sampled &&
            !next_s.locked && !next_s.lvl[4];
        next_s.trace = next_s.trace_oe && trace_data_i;
        if (next_s.lvl[4])
            next_s.pins_used = next_s.lvl[3] ? dbg_pkg::PINS_SCAN5
                                             : dbg_pkg::PINS_SCAN4;
        else if (next_s.lvl[2])
            next_s.pins_used = next_s.trace_oe ? dbg_pkg::PINS_SWD_TRACE
                                               : dbg_pkg::PINS_SWD;
        else
            next_s.pins_used = next_s.trace_oe ? dbg_pkg::PINS_TRACE
                                               : dbg_pkg::PINS_NONE;
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s <= '0;
            s.mode <= dbg_pkg::NV_PORT_DEFAULT;
        end
        else
        begin
            s <= next_s;
        end
    end

    // link side: test access port on the test clock
    assign one_bit_dr = t.ir == dbg_pkg::INSTR_BYPASS ||
                        t.ir == dbg_pkg::INSTR_RESET;
    assign tap_hold = !scan_on_t || (scan5_t && !pins_t[8]);

    always_comb
    begin
        next_t = t;
        if (tap_hold)
        begin
            next_t.tap = dbg_pkg::TAP_RESET;
        end
        else
        begin
            unique case (t.tap)
                dbg_pkg::TAP_RESET: next_t.tap = tms_i ? dbg_pkg::TAP_RESET
                                                       : dbg_pkg::TAP_IDLE;
                dbg_pkg::TAP_IDLE: next_t.tap = tms_i ? dbg_pkg::TAP_SEL_DR
                                                      : dbg_pkg::TAP_IDLE;
                dbg_pkg::TAP_SEL_DR: next_t.tap = tms_i ? dbg_pkg::TAP_SEL_IR
                                                       : dbg_pkg::TAP_CAP_DR;
                dbg_pkg::TAP_CAP_DR, dbg_pkg::TAP_SH_DR:
                    next_t.tap = tms_i ? dbg_pkg::TAP_EX1_DR
                                       : dbg_pkg::TAP_SH_DR;
                dbg_pkg::TAP_EX1_DR: next_t.tap = tms_i ? dbg_pkg::TAP_UPD_DR
                                                       : dbg_pkg::TAP_PAU_DR;
                dbg_pkg::TAP_PAU_DR: next_t.tap = tms_i ? dbg_pkg::TAP_EX2_DR
                                                       : dbg_pkg::TAP_PAU_DR;
                dbg_pkg::TAP_EX2_DR: next_t.tap = tms_i ? dbg_pkg::TAP_UPD_DR
                                                       : dbg_pkg::TAP_SH_DR;
                dbg_pkg::TAP_UPD_DR, dbg_pkg::TAP_UPD_IR:
                    next_t.tap = tms_i ? dbg_pkg::TAP_SEL_DR
                                       : dbg_pkg::TAP_IDLE;
                dbg_pkg::TAP_SEL_IR: next_t.tap = tms_i ? dbg_pkg::TAP_RESET
                                                       : dbg_pkg::TAP_CAP_IR;
                dbg_pkg::TAP_CAP_IR, dbg_pkg::TAP_SH_IR:
                    next_t.tap = tms_i ? dbg_pkg::TAP_EX1_IR
                                       : dbg_pkg::TAP_SH_IR;
                dbg_pkg::TAP_EX1_IR: next_t.tap = tms_i ? dbg_pkg::TAP_UPD_IR
                                                       : dbg_pkg::TAP_PAU_IR;
                dbg_pkg::TAP_PAU_IR: next_t.tap = tms_i ? dbg_pkg::TAP_EX2_IR
                                                       : dbg_pkg::TAP_PAU_IR;
                dbg_pkg::TAP_EX2_IR: next_t.tap = tms_i ? dbg_pkg::TAP_UPD_IR
                                                       : dbg_pkg::TAP_SH_IR;
            endcase
        end
        unique case (t.tap)
            dbg_pkg::TAP_RESET:
            begin
                next_t.ir = dbg_pkg::INSTR_BYPASS;
                next_t.extest = 1'b0;
            end
            dbg_pkg::TAP_CAP_DR:
                if (t.ir == dbg_pkg::INSTR_DEBUG)
                    next_t.dr_sh = lk.rd_data;
                else if (!one_bit_dr)
                    next_t.dr_sh = pins_t[7:0];
                else
                    next_t.dr_sh = 8'h00;
            dbg_pkg::TAP_SH_DR:
                if (one_bit_dr)
                    next_t.dr_sh = {7'h00, tdi_i};
                else
                    next_t.dr_sh = {tdi_i, t.dr_sh[7:1]};
            dbg_pkg::TAP_UPD_DR:
                if (t.ir == dbg_pkg::INSTR_EXTEST)
                    next_t.bs_out = t.dr_sh;
                else if (t.ir == dbg_pkg::INSTR_DEBUG)
                begin
                    next_t.cmd = t.dr_sh;
                    next_t.cmd_tog = ~t.cmd_tog;
                end
                else if (t.ir == dbg_pkg::INSTR_RESET && t.dr_sh[0])
                    next_t.rst_tog = ~t.rst_tog;
            dbg_pkg::TAP_CAP_IR:
                next_t.ir_sh = 4'h1;
            dbg_pkg::TAP_SH_IR:
                next_t.ir_sh = {tdi_i, t.ir_sh[3:1]};
            dbg_pkg::TAP_UPD_IR:
            begin
                next_t.ir = t.ir_sh;
                next_t.extest = t.ir_sh == dbg_pkg::INSTR_EXTEST;
            end
            default:
                next_t.ir = t.ir;
        endcase
        next_t.tdo_oe = next_t.tap == dbg_pkg::TAP_SH_DR ||
                        next_t.tap == dbg_pkg::TAP_SH_IR;
        next_t.tdo = next_t.tap == dbg_pkg::TAP_SH_IR ? next_t.ir_sh[0]
                                                      : next_t.dr_sh[0];
    end

    always_ff @(posedge tck_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            t <= '0;
            t.ir <= dbg_pkg::INSTR_BYPASS;
        end
        else
        begin
            t <= next_t;
        end
    end

    assign tms_o = lk.tms_o;
    assign tms_oe_o = lk.tms_oe;
    assign tdo_o = t.tdo;
    assign tdo_oe_o = t.tdo_oe;
    assign scan_out_o = t.bs_out;
    assign extest_o = t.extest;
    assign trace_o = s.trace;
    assign trace_oe_o = s.trace_oe;
    assign debug_enable_o = s.lvl[0];
    assign dbg_cmd_o = s.dbg_cmd;
    assign dbg_cmd_valid_o = s.dbg_cmd_valid;
    assign reset_req_o = s.reset_req;
    assign pins_used_o = s.pins_used;
    assign port_mode_o = s.mode;
endmodule // debug_port_access_control

//--- dv/dbg_port_properties.sv
`timescale 1ns/1ps
module dbg_port_properties (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic tck_i,
    input wire logic lockout_i,
    input wire logic fw_debug_enable_i,
    input wire logic tms_oe_o,
    input wire logic trace_oe_o,
    input wire logic debug_enable_o,
    input wire logic dbg_cmd_valid_o,
    input wire logic reset_req_o,
    input wire logic [2:0] pins_used_o,
    input wire logic [1:0] port_mode_o
);
    a_debug_from_fw: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        $rose(debug_enable_o) |-> $past(fw_debug_enable_i)
        || $past(fw_debug_enable_i, 2) || $past(fw_debug_enable_i, 3))
        else $error("debug on without firmware");
    a_lock_quiet: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        lockout_i |=> !debug_enable_o && !reset_req_o
        && pins_used_o == 3'h0)
        else $error("locked part still open");
    a_none_no_reset: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        port_mode_o == 2'h0 |-> !reset_req_o)
        else $error("reset request with ports off");
    a_scan_tms_in: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        pins_used_o[2] |-> !tms_oe_o)
        else $error("tms driven in scan mode");
    a_read_eight: assert property (
        @(posedge tck_i) disable iff (reset_i)
        $rose(tms_oe_o) |-> tms_oe_o [*8] ##1 !tms_oe_o)
        else $error("read drive not eight cycles");
    a_reset_one: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        reset_req_o |=> !reset_req_o)
        else $error("reset request too long");
    a_cmd_needs_dbg: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        dbg_cmd_valid_o |-> debug_enable_o)
        else $error("command while debug off");
    a_no_trace_scan: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        pins_used_o[2] |-> !trace_oe_o)
        else $error("trace pin used in scan mode");
endmodule // dbg_port_properties
bind debug_port_access_control dbg_port_properties chk_u (.*);

//--- dv/host_model.sv
`timescale 1ns/1ps
module host_model (
    output logic tck_o,
    output logic tms_o,
    output logic tms_en_o,
    output logic tdi_o,
    output logic trst_n_o,
    input wire logic tdo_i,
    input wire logic dev_oe_i
);
    logic q;
    initial
        {tck_o, tms_o, tms_en_o, tdi_o, trst_n_o, q} = 6'h0a;
    // one clock; frames keep updates far apart
    task automatic tick(input logic t, input logic d);
        tms_o = t;
        tdi_o = d;
        #40;
        q = tdo_i;
        tck_o = 1'b1;
        #40;
        tck_o = 1'b0;
    endtask
    task automatic tap_reset();
        repeat (5) tick(1'b1, 1'b0);
        tick(1'b0, 1'b0);
    endtask
    task automatic shift(input logic ir, input logic [7:0] v,
        input int n, output logic [7:0] got);
        got = 8'h00;
        tick(1'b1, 1'b0);
        if (ir)
            tick(1'b1, 1'b0);
        tick(1'b0, 1'b0);
        tick(1'b0, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, v[i]);
            got[i] = q;
        end
        tick(1'b1, 1'b0);
        tick(1'b0, 1'b0);
    endtask
    task automatic acquire();
        repeat (3) tick(1'b0, 1'b0);
        for (int i = 15; i >= 0; i--)
            tick(dbg_pkg::ACQ_SEQ[i], 1'b0);
        repeat (8) tick(1'b0, 1'b0);
    endtask
    task automatic swd_write(input logic [7:0] v);
        tick(1'b1, 1'b0);
        tick(1'b0, 1'b0);
        for (int i = 0; i < 8; i++)
            tick(v[i], 1'b0);
        repeat (3) tick(1'b0, 1'b0);
    endtask
    task automatic swd_read(output int n);
        n = 0;
        tick(1'b1, 1'b0);
        tick(1'b1, 1'b0);
        tms_en_o = 1'b0;
        repeat (10)
        begin
            tick(1'b1, 1'b0);
            n += int'(dev_oe_i);
        end
        tms_en_o = 1'b1;
        tick(1'b0, 1'b0);
    endtask
endmodule // host_model

//--- dv/testbench.sv
`timescale 1ns/1ps
`define CHK(a, e) \
    begin \
        cmp_count++; \
        if ((a) !== (e)) \
        begin \
            bad_count++; \
            $display("CHECK FAILED at %0t: %0h not %0h", $time, a, e); \
        end \
    end
module testbench;
    logic sys_clk_i, reset_i, tck_i, tms_i, tdi_i, test_reset_n_i;
    logic [1:0] nv_port_select_i, port_mode_o;
    logic nv_trace_en_i, nv_sealed_i, lockout_i, fw_debug_enable_i;
    logic fw_seal_i, erase_done_i, protect_clear_i, trace_data_i;
    logic [7:0] pin_state_i, scan_out_o, dbg_cmd_o, got;
    logic tms_o, tms_oe_o, tdo_o, tdo_oe_o, extest_o, trace_o;
    logic trace_oe_o, debug_enable_o, dbg_cmd_valid_o, reset_req_o;
    logic [2:0] pins_used_o;
    logic h_tms, h_en;
    int bad_count, cmp_count, cyc, req_n, n, vld_n;
    assign tms_i = tms_oe_o ? tms_o : (h_en ? h_tms : ~h_tms);
    host_model host_u (.tck_o(tck_i), .tms_o(h_tms), .tms_en_o(h_en),
        .tdi_o(tdi_i), .trst_n_o(test_reset_n_i), .tdo_i(tdo_o),
        .dev_oe_i(tms_oe_o));
    debug_port_access_control dut_u (.*);
    initial
    begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (reset_req_o === 1'b1)
            req_n++;
        if (dbg_cmd_valid_o === 1'b1)
            vld_n++;
        if (cyc == 20000)
        begin
            bad_count++;
            complete_run();
        end
    end
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk_i);
        #5;
    endtask
    task automatic boot(input logic [1:0] s, input logic lk,
        input logic sl, input logic tr);
        reset_i = 1'b1;
        {nv_port_select_i, lockout_i, nv_sealed_i, nv_trace_en_i} =
            {s, lk, sl, tr};
        host_u.tick(1'b0, 1'b0);
        step(16);
        reset_i = 1'b0;
        step(3);
    endtask
    // pulse enable, seal, erase, clear
    task automatic fw(input logic [3:0] m);
        {fw_debug_enable_i, fw_seal_i, erase_done_i, protect_clear_i} = m;
        step(1);
        {fw_debug_enable_i, fw_seal_i, erase_done_i, protect_clear_i} = 0;
        step(3);
    endtask
    function automatic logic [2:0] pins(input logic [1:0] s,
        input logic t);
        case (s)
            2'h0: return {2'h0, t};
            2'h2: return {2'h1, t};
            default: return {2'h2, s[1]};
        endcase
    endfunction
    task automatic t_straps();
        for (int i = 0; i < 8; i++)
        begin
            boot(i[2:1], 1'b0, 1'b0, i[0]);
            `CHK(port_mode_o, i[2:1])
            `CHK(pins_used_o, pins(i[2:1], i[0]))
            `CHK(trace_oe_o, i[0] & ~i[1])
            `CHK(trace_o, i[0] & ~i[1])
            `CHK(tms_oe_o, 1'b0)
            `CHK(debug_enable_o, 1'b0)
        end
        $display("straps done");
    endtask
    task automatic t_firmware();
        boot(2'h1, 1'b0, 1'b0, 1'b0);
        fw(4'h4);
        fw(4'h8);
        `CHK(debug_enable_o, 1'b0)
        fw(4'h2);
        fw(4'h8);
        `CHK(debug_enable_o, 1'b0)
        fw(4'h1);
        fw(4'h8);
        `CHK(debug_enable_o, 1'b1)
        boot(2'h1, 1'b0, 1'b1, 1'b0);
        fw(4'h8);
        `CHK(debug_enable_o, 1'b0)
        boot(2'h1, 1'b0, 1'b0, 1'b0);
        fw(4'h8);
        `CHK(debug_enable_o, 1'b1)
        $display("firmware done");
    endtask
    task automatic t_reset();
        for (int i = 0; i < 3; i++)
        begin
            boot(i == 2 ? 2'h0 : 2'h1, i == 1, 1'b0, 1'b0);
            req_n = 0;
            host_u.tap_reset();
            host_u.shift(1'b1, {4'h0, dbg_pkg::INSTR_RESET}, 4, got);
            host_u.shift(1'b0, 8'h01, 1, got);
            step(8);
            `CHK(req_n, i == 0)
        end
        `CHK(pins_used_o, 3'h0)
        $display("reset request done");
    endtask
    task automatic t_scan();
        boot(2'h1, 1'b0, 1'b0, 1'b0);
        fw(4'h8);
        pin_state_i = 8'ha6;
        host_u.tap_reset();
        host_u.shift(1'b1, {4'h0, dbg_pkg::INSTR_SAMPLE}, 4, got);
        `CHK(got, 8'h01)
        host_u.shift(1'b0, 8'h00, 8, got);
        `CHK(got, 8'ha6)
        host_u.shift(1'b1, {4'h0, dbg_pkg::INSTR_EXTEST}, 4, got);
        host_u.shift(1'b0, 8'h3d, 8, got);
        `CHK(scan_out_o, 8'h3d)
        `CHK(extest_o, 1'b1)
        host_u.shift(1'b1, {4'h0, dbg_pkg::INSTR_DEBUG}, 4, got);
        host_u.shift(1'b0, 8'h5a, 8, got);
        step(6);
        `CHK(dbg_cmd_o, 8'h5a)
        `CHK(vld_n, 1)
        $display("scan done");
    endtask
    task automatic t_swd();
        boot(2'h1, 1'b0, 1'b0, 1'b0);
        fw(4'h8);
        host_u.acquire();
        step(4);
        `CHK(pins_used_o, 3'h2)
        host_u.swd_read(n);
        `CHK(n, 8)
        host_u.swd_write(8'h21);
        step(6);
        `CHK(dbg_cmd_o, 8'h21)
        host_u.swd_write(dbg_pkg::CMD_TO_SCAN);
        step(6);
        `CHK(pins_used_o, 3'h4)
        `CHK(vld_n, 2)
        host_u.swd_read(n);
        `CHK(n, 0)
        boot(2'h1, 1'b0, 1'b0, 1'b0);
        step(100);
        host_u.acquire();
        step(4);
        `CHK(pins_used_o, 3'h4)
        $display("two-wire done");
    endtask
    initial
    begin
        {bad_count, cmp_count, cyc, req_n} = 0;
        {fw_debug_enable_i, fw_seal_i, erase_done_i, protect_clear_i} = 0;
        trace_data_i = 1'b1;
        pin_state_i = 8'h00;
        t_straps();
        t_firmware();
        t_reset();
        t_scan();
        t_swd();
        complete_run();
    end
endmodule // testbench
